// ===== rtl/tcp_core.sv
module tcp_core (
    input wire logic mclk, // Clock
    input wire logic rst, // Sync reset
    input wire logic external_count_input, // Count pin, synchronous
    tcp_ctl_if.core ctl // Control
);
    typedef struct packed {
        logic [7:0] count;
        logic [1:0] hold;
        logic pin_prev;
    } tcp_core_type;
    tcp_core_type s_reg, s_next;
    logic cs, se, to_wdog, edge_ev, src_ev, pre_in, pre_out, pre_clr, adv;
    assign cs = ctl.option[tcp_pkg::OPT_CS_BIT];
    assign se = ctl.option[tcp_pkg::OPT_SE_BIT];
    assign to_wdog = ctl.option[tcp_pkg::OPT_ASSIGN_BIT];
    assign edge_ev = se ? (s_reg.pin_prev & ~external_count_input)
                        : (~s_reg.pin_prev & external_count_input);
    assign src_ev = cs ? edge_ev : 1'b1;
    // Prescaler sees exactly one client at a time
    assign pre_in = to_wdog ? 1'b1 : src_ev;
    assign pre_clr = to_wdog ? ctl.wdog_clear : ctl.count_we;
    tcp_prescaler #(.WIDTH(8)) u_pre (
        .mclk(mclk),
        .rst(rst),
        .tick_in(pre_in),
        .clear(pre_clr),
        .ratio_sel(ctl.option[tcp_pkg::OPT_RATIO_MSB:0]),
        .tick_out(pre_out)
    );
    assign adv = to_wdog ? src_ev : pre_out;
    always_comb begin
        s_next = s_reg;
        s_next.pin_prev = external_count_input;
        if (ctl.count_we) begin
            s_next.count = ctl.count_wdata;
            s_next.hold = 2'(tcp_pkg::WRITE_HOLD_CYCLES);
        end else if (s_reg.hold != 2'h0) begin
            s_next.hold = s_reg.hold - 2'h1;
        end else if (adv) begin
            s_next.count = s_reg.count + 8'h01;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign ctl.count = s_reg.count;
    assign ctl.wdog_tick = to_wdog ? pre_out : 1'b1;
    property p_hold;
        @(posedge mclk) disable iff (rst)
        ctl.count_we ##1 !ctl.count_we
        |-> ##1 (s_reg.count == $past(s_reg.count));
    endproperty
    a_hold: assert property (p_hold) else $error("count moved in hold");
    property p_hold2;
        @(posedge mclk) disable iff (rst)
        ctl.count_we ##1 !ctl.count_we ##1 !ctl.count_we
        |-> ##1 (s_reg.count == $past(s_reg.count));
    endproperty
    a_hold2: assert property (p_hold2) else $error("second hold lost");
    property p_wrap;
        @(posedge mclk) disable iff (rst)
        s_reg.count == 8'hff && s_reg.hold == 2'h0 && adv && !ctl.count_we
        |=> s_reg.count == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");
    property p_timer;
        @(posedge mclk) disable iff (rst)
        !cs && to_wdog && s_reg.hold == 2'h0 && !ctl.count_we
        |=> s_reg.count == $past(s_reg.count) + 8'h01;
    endproperty
    a_timer: assert property (p_timer) else $error("timer stalled");
    property p_pre_clr;
        @(posedge mclk) disable iff (rst)
        pre_clr |=> u_pre.s_reg.cnt == 8'h00;
    endproperty
    a_pre_clr: assert property (p_pre_clr) else $error("prescaler kept");
endmodule

// ===== rtl/tcp_prescaler.sv
module tcp_prescaler #(
    parameter int WIDTH = 8
) (
    input wire logic mclk, // Clock
    input wire logic rst, // Sync reset
    input wire logic tick_in, // Source event
    input wire logic clear, // Clear counter
    input wire logic [2:0] ratio_sel, // Ratio code
    output logic tick_out // Divided event
);
    // Three ratio bits tap exactly eight counter stages
    if (WIDTH != 8) begin : g_width_check
        $error("prescaler width must be 8");
    end
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic out;
    } tcp_pre_type;
    tcp_pre_type s_reg, s_next;
    logic [WIDTH-1:0] inc;
    always_comb begin
        s_next = s_reg;
        s_next.out = 1'b0;
        inc = s_reg.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
        if (clear) begin
            s_next.cnt = '0;
        end else if (tick_in) begin
            s_next.cnt = inc;
            // Carry out of bit n, so a clear costs one whole period
            s_next.out = s_reg.cnt[ratio_sel] & ~inc[ratio_sel];
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) s_reg <= '0;
        else s_reg <= s_next;
    end
    assign tick_out = s_reg.out;
endmodule

// ===== rtl/tcp_timer.sv
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
module tcp_timer (
    input wire logic mclk, // Clock
    input wire logic rst, // Sync reset
    input wire logic external_count_input, // Count pin
    input wire logic watchdog_clear_instruction, // Watchdog clear pulse
    output logic watchdog_tick, // Tick to watchdog
    input wire logic [3:0] s_axi_awaddr, // AW
    input wire logic s_axi_awvalid, // AW
    output logic s_axi_awready, // AW
    input wire logic [31:0] s_axi_wdata, // W
    input wire logic [3:0] s_axi_wstrb, // W
    input wire logic s_axi_wvalid, // W
    output logic s_axi_wready, // W
    output logic [1:0] s_axi_bresp, // B
    output logic s_axi_bvalid, // B
    input wire logic s_axi_bready, // B
    input wire logic [3:0] s_axi_araddr, // AR
    input wire logic s_axi_arvalid, // AR
    output logic s_axi_arready, // AR
    output logic [31:0] s_axi_rdata, // R
    output logic [1:0] s_axi_rresp, // R
    output logic s_axi_rvalid, // R
    input wire logic s_axi_rready // R
);
    typedef struct packed {
        logic [7:0] option;
        logic aw_ok;
        logic [3:0] awaddr;
        logic w_ok;
        logic [7:0] wdata;
        logic wlane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic wdog_tick;
        logic awready;
        logic wready;
        logic arready;
    } tcp_bus_type;
    tcp_bus_type s_reg, s_next;
    tcp_ctl_if ctl ();
    logic do_write;
    tcp_core u_core (
        .mclk(mclk),
        .rst(rst),
        .external_count_input(external_count_input),
        .ctl(ctl)
    );
    assign do_write = s_reg.aw_ok && s_reg.w_ok && !s_reg.bvalid;
    assign ctl.option = s_reg.option;
    assign ctl.count_we = do_write && s_reg.wlane
        && s_reg.awaddr == tcp_pkg::ADDR_COUNT;
    assign ctl.count_wdata = s_reg.wdata;
    assign ctl.wdog_clear = watchdog_clear_instruction;
    always_comb begin
        s_next = s_reg;
        s_next.wdog_tick = ctl.wdog_tick;
        if (s_axi_awvalid && !s_reg.aw_ok) begin
            s_next.aw_ok = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.w_ok) begin
            s_next.w_ok = 1'b1;
            s_next.wdata = s_axi_wdata[7:0];
            s_next.wlane = s_axi_wstrb[0];
        end
        if (do_write) begin
            s_next.aw_ok = 1'b0;
            s_next.w_ok = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = tcp_pkg::RESP_OKAY;
            if (s_reg.awaddr == tcp_pkg::ADDR_OPTION) begin
                if (s_reg.wlane) s_next.option = s_reg.wdata;
            end else if (s_reg.awaddr != tcp_pkg::ADDR_COUNT) begin
                // Prescaler count has no address at all
                s_next.bresp = tcp_pkg::RESP_SLVERR;
            end
        end
        if (s_reg.bvalid && s_axi_bready) s_next.bvalid = 1'b0;
        if (s_axi_arvalid && !s_reg.rvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = tcp_pkg::RESP_OKAY;
            case (s_axi_araddr)
                tcp_pkg::ADDR_COUNT: s_next.rdata = {24'h0, ctl.count};
                tcp_pkg::ADDR_OPTION: s_next.rdata = {24'h0, s_reg.option};
                tcp_pkg::ADDR_STATUS: begin
                    s_next.rdata = 32'h0;
                    s_next.rdata[0] = s_reg.option[tcp_pkg::OPT_ASSIGN_BIT];
                end
                default: begin
                    s_next.rdata = 32'h0;
                    s_next.rresp = tcp_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        // Ready flags are registered so the ports come from flops
        s_next.awready = !s_next.aw_ok;
        s_next.wready = !s_next.w_ok;
        s_next.arready = !s_next.rvalid;
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.option <= tcp_pkg::OPTION_RESET;
            s_reg.awready <= 1'b1;
            s_reg.wready <= 1'b1;
            s_reg.arready <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end
    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign watchdog_tick = s_reg.wdog_tick;
    // Prescaler on the timer leaves the watchdog undivided
    property p_route;
        @(posedge mclk) disable iff (rst)
        !s_reg.option[tcp_pkg::OPT_ASSIGN_BIT] |=> s_reg.wdog_tick;
    endproperty
    a_route: assert property (p_route) else $error("watchdog divided");
endmodule

// ===== shared/tcp_ctl_if.sv
interface tcp_ctl_if;
    logic [7:0] option;
    logic count_we;
    logic [7:0] count_wdata;
    logic [7:0] count;
    logic wdog_tick;
    logic wdog_clear;
    modport core (input option, count_we, count_wdata, wdog_clear,
        output count, wdog_tick);
    modport regs (output option, count_we, count_wdata, wdog_clear,
        input count, wdog_tick);
endinterface

// ===== shared/tcp_pkg.sv
// Function
// - Clock source select cleared: count internal instruction cycles.
// - Timer mode without prescaler: count advances every cycle.
// - A count write holds counting off for the next two cycles.
// - Clock source select set: count edges of external count input.
// - Edge select cleared counts rising edges, set counts falling edges.
// - Prescaler serves the timer or the watchdog, never both.
// - Assign bit cleared routes prescaler to timer, set to watchdog.
// - Prescaler counter has no software read or write path.
// - Timer ratios run in powers of two from 1:2 to 1:256.
// - Timer count is eight bits, readable and writable.
// - Count write clears the prescaler when it serves the timer.
// - Watchdog clear clears the prescaler when it serves the watchdog.
// - Any reset clears the prescaler to zero.
// - Ratio field and assign bit occupy option bits three to zero.
package tcp_pkg;
    localparam logic [3:0] ADDR_COUNT = 4'h0;
    localparam logic [3:0] ADDR_OPTION = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [7:0] OPTION_RESET = 8'hff;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam int OPT_CS_BIT = 5;
    localparam int OPT_SE_BIT = 4;
    localparam int OPT_ASSIGN_BIT = 3;
    localparam int OPT_RATIO_MSB = 2;
    localparam int WRITE_HOLD_CYCLES = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== tb/tcp_pulse_src.sv
module tcp_pulse_src (
    input wire logic mclk, // Clock
    output logic pin // External count input
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin = 1'b0;
    // Pin keeps its level between runs, as a driven input would
    task automatic run(input int toggles, input int gap);
        repeat (toggles) begin
            repeat (gap) @(posedge mclk);
            pin <= ~pin;
        end
    endtask
endmodule

// ===== tb/tcp_timer_bench.sv
module tcp_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(g, e) begin \
        tests_run++; \
        if ((g) !== (e)) begin \
            err_count++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
    logic mclk, rst = 1'b1, watchdog_clear_instruction = 1'b0;
    logic external_count_input, watchdog_tick;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h1;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, wb, rrv;
    int err_count = 0, tests_run = 0, cyc = 0, wdog_n = 0, rt, wt;

    tcp_timer dut (.mclk, .rst, .external_count_input,
        .watchdog_clear_instruction, .watchdog_tick, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    tcp_pulse_src src (.mclk(mclk), .pin(external_count_input));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        wdog_n <= wdog_n + int'(watchdog_tick);
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        wb = s_axi_bresp;
        wt = cyc;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        rt = cyc;
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        rdv = s_axi_rdata;
        rrv = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Written value stands through the write cycle and two held cycles
    function automatic logic [7:0] held(logic [7:0] d, int span);
        return (span > 2) ? d + 8'(span - 2) : d;
    endfunction
    task automatic do_rst;
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
    endtask

    task automatic t_reset;
        rd(tcp_pkg::ADDR_OPTION);
        `CHK(rdv, {24'h0, tcp_pkg::OPTION_RESET})
        rd(tcp_pkg::ADDR_COUNT);
        `CHK(rdv, {24'h0, tcp_pkg::COUNT_RESET})
        rd(4'hc);
        `CHK({rrv, rdv}, {tcp_pkg::RESP_SLVERR, 32'h0})
        wr(4'hc, 8'h55);
        `CHK(wb, tcp_pkg::RESP_SLVERR)
        $display("reset test done");
    endtask
    task automatic t_hold;
        wr(tcp_pkg::ADDR_OPTION, 8'h08);
        wr(tcp_pkg::ADDR_COUNT, 8'hfe);
        rd(tcp_pkg::ADDR_COUNT);
        `CHK(rdv[7:0], held(8'hfe, rt - wt))
        repeat (6) @(posedge mclk);
        rd(tcp_pkg::ADDR_COUNT);
        `CHK(rdv[7:0], held(8'hfe, rt - wt))
        $display("hold test done");
    endtask
    task automatic t_ratio;
        int r;
        int t1;
        logic [7:0] v1, o;
        logic ok;
        for (int i = 0; i < 9; i++) begin
            r = (i == 8) ? 1 : 2 << i;
            o = (i == 8) ? 8'h08 : 8'(i);
            wr(tcp_pkg::ADDR_OPTION, o);
            wr(tcp_pkg::ADDR_COUNT, 8'h00);
            repeat (4) @(posedge mclk);
            rd(tcp_pkg::ADDR_COUNT);
            v1 = rdv[7:0];
            t1 = rt;
            repeat (2 * r) @(posedge mclk);
            rd(tcp_pkg::ADDR_COUNT);
            v1 = rdv[7:0] - v1;
            t1 = rt - t1;
            ok = v1 == 8'(t1 / r) || (t1 % r != 0 && v1 == 8'(t1 / r + 1));
            `CHK(ok, 1'b1)
            rd(tcp_pkg::ADDR_OPTION);
            `CHK(rdv, {24'h0, o})
            rd(tcp_pkg::ADDR_STATUS);
            `CHK(rdv, {31'h0, i == 8})
        end
        $display("ratio test done");
    endtask
    task automatic t_count;
        wr(tcp_pkg::ADDR_OPTION, 8'h28);
        wr(tcp_pkg::ADDR_COUNT, 8'h00);
        src.run(7, 5);
        repeat (5) @(posedge mclk);
        rd(tcp_pkg::ADDR_COUNT);
        `CHK(rdv[7:0], 8'h04)
        wr(tcp_pkg::ADDR_OPTION, 8'h38);
        wr(tcp_pkg::ADDR_COUNT, 8'h00);
        src.run(7, 2);
        repeat (5) @(posedge mclk);
        rd(tcp_pkg::ADDR_COUNT);
        `CHK(rdv[7:0], 8'h04)
        wr(tcp_pkg::ADDR_OPTION, 8'h20);
        wr(tcp_pkg::ADDR_COUNT, 8'h00);
        src.run(8, 2);
        repeat (5) @(posedge mclk);
        rd(tcp_pkg::ADDR_COUNT);
        `CHK(rdv[7:0], 8'h02)
        $display("counter test done");
    endtask
    task automatic t_wdt;
        int n0;
        wr(tcp_pkg::ADDR_OPTION, 8'h09);
        // A clear every third cycle must starve a 1:4 watchdog ratio
        for (int k = 0; k < 10; k++) begin
            @(posedge mclk);
            watchdog_clear_instruction <= 1'b1;
            @(posedge mclk);
            watchdog_clear_instruction <= 1'b0;
            @(posedge mclk);
            if (k == 1) n0 = wdog_n;
        end
        `CHK(wdog_n - n0, 0)
        repeat (4) @(posedge mclk);
        n0 = wdog_n;
        repeat (40) @(posedge mclk);
        `CHK(wdog_n - n0, 10)
        wr(tcp_pkg::ADDR_OPTION, 8'h01);
        repeat (2) @(posedge mclk);
        n0 = wdog_n;
        repeat (20) @(posedge mclk);
        `CHK(wdog_n - n0, 20)
        $display("watchdog test done");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        do_rst;
        t_reset;
        t_hold;
        t_ratio;
        t_count;
        t_wdt;
        do_rst;
        t_reset;
        finish_test;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        finish_test;
    end
endmodule
